// File: hcr_bist.sv
// Self-test engine holding one packet memory, run with a write pass and a compare pass twice.
// Assumes i_run comes from logic on the same clock; a rising i_run clears the results.
`timescale 1ns/100ps
`include "hcr_map.svh"

module hcr_bist (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_run,
  output logic            o_done,
  output logic            o_fail,
  output logic [2:0]      o_cnt
);
  import hcr_pkg::*;

  localparam logic [`HCR_MEM_AW-1:0] LAST = '1;

  hcr_bist_state_t        r;
  hcr_bist_state_t        n;
  logic [`HCR_MEM_W-1:0]  mem [2**`HCR_MEM_AW];
  logic [`HCR_MEM_W-1:0]  rd_q;
  logic [`HCR_MEM_W-1:0]  pat;

  assign pat = {r.pass, {3{r.addr}}} ^ `HCR_MEM_PAT ^ {`HCR_MEM_W{r.pass}};

  always_comb begin
    n = r;
    n.run_q = i_run;
    n.chk = 1'b0;
    if (r.chk && rd_q != r.exp) begin
      n.fail = 1'b1;
      if (r.cnt != 3'h7) begin
        n.cnt = r.cnt + 3'h1;
      end
    end
    case (r.ph)
      HCR_B_WR: begin
        n.addr = r.addr + 1'b1;
        if (r.addr == LAST) begin
          n.ph = HCR_B_RD;
        end
      end
      HCR_B_RD: begin
        n.chk = 1'b1;
        n.exp = pat;
        n.addr = r.addr + 1'b1;
        if (r.addr == LAST) begin
          n.ph = HCR_B_CHK;
        end
      end
      HCR_B_CHK: begin
        if (!r.chk) begin
          n.pass = 1'b1;
          n.ph = r.pass ? HCR_B_IDLE : HCR_B_WR;
          n.done = r.pass;
        end
      end
      default: begin
        n.ph = HCR_B_IDLE;
      end
    endcase
    if (i_run && !r.run_q) begin
      n = '0;
      n.run_q = 1'b1;
      n.ph = HCR_B_WR;
    end else if (!i_run) begin
      n.ph = HCR_B_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (r.ph == HCR_B_WR) begin
      mem[r.addr] <= pat;
    end
    rd_q <= mem[r.addr];
  end

  assign o_done = r.done;
  assign o_fail = r.fail;
  assign o_cnt  = r.cnt;

endmodule

// File: hcr_map.svh
// Offsets, field positions, reset values and timing counts of the host configuration block.
// Assumes a 125 MHz system clock and byte addresses on a 9-bit register port.
`ifndef HCR_MAP_SVH
`define HCR_MAP_SVH

`define HCR_OFF_CFG        9'h108
`define HCR_OFF_MAC_LO     9'h110
`define HCR_OFF_MAC_MID    9'h112
`define HCR_OFF_MAC_HI     9'h114
`define HCR_OFF_PROM_CTL   9'h122
`define HCR_OFF_BIST_STAT  9'h124
`define HCR_OFF_GLB_RST    9'h126

`define HCR_CFG_ENDIAN     10
`define HCR_CFG_PRESENT    9
`define HCR_CFG_W8         7
`define HCR_CFG_W16        6
`define HCR_CFG_SHARED     4
`define HCR_CFG_LOW_RST    4'h2

`define HCR_CTL_DIR        5
`define HCR_CTL_EN         4
`define HCR_CTL_DIN        3
`define HCR_CTL_DOUT       2
`define HCR_CTL_SK         1
`define HCR_CTL_CS         0

`define HCR_ST_DONE        15
`define HCR_GRR_BIST       3

`define HCR_MAC_FIRST      2'h1
`define HCR_MAC_LAST       2'h3
`define HCR_PROM_READ_OP   3'h6
`define HCR_PROM_BITS      5'h19
`define HCR_PROM_DATA_BITS 5'h10
`define HCR_SYNC_WAIT      2'h3

`define HCR_CLK_MHZ        125
`define HCR_PROM_HALF_NS   500
`define HCR_PROM_HALF_CYC  ((`HCR_PROM_HALF_NS * `HCR_CLK_MHZ + 999) / 1000)

`define HCR_MEM_AW         5
`define HCR_MEM_W          16
`define HCR_MEM_PAT        16'h5A5A

`endif

// File: hcr_pkg.sv
// Types shared by the host configuration block and its memory self-test engine.
// Assumes hcr_map.svh is on the include path.
`include "hcr_map.svh"

package hcr_pkg;

  typedef enum logic [1:0] {HCR_SYNC, HCR_LOAD, HCR_GAP, HCR_IDLE} hcr_state_t;
  typedef enum logic [1:0] {HCR_B_IDLE, HCR_B_WR, HCR_B_RD, HCR_B_CHK} hcr_bphase_t;

  typedef struct packed {
    hcr_state_t       st;
    logic [1:0]       wait_cnt;
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic             endian;
    logic             present;
    logic             wide16;
    logic [6:0]       div;
    logic             ph;
    logic [4:0]       bits;
    logic [1:0]       word;
    logic [15:0]      sh;
    logic             ld_cs;
    logic             ld_sk;
    logic [2:0][15:0] mac;
    logic             ee_dir;
    logic             ee_en;
    logic             ee_dout;
    logic             ee_sk;
    logic             ee_cs;
    logic             cs_o;
    logic             sk_o;
    logic             do_o;
    logic             oe_n;
    logic             grr_bist;
    logic             bist_run;
    logic [15:0]      rdata;
  } hcr_top_state_t;

  typedef struct packed {
    hcr_bphase_t            ph;
    logic                   run_q;
    logic                   pass;
    logic [`HCR_MEM_AW-1:0] addr;
    logic                   chk;
    logic [`HCR_MEM_W-1:0]  exp;
    logic                   done;
    logic                   fail;
    logic [2:0]             cnt;
  } hcr_bist_state_t;

endpackage

// File: hcr_prom_model.sv
// Behavioural serial configuration PROM that answers the read command.
// Assumes the device drives select, clock and data out and splits the data pin with an enable.
`timescale 1ns/100ps

module hcr_prom_model #(
  parameter logic [15:0] W1 = 16'h89AB,
  parameter logic [15:0] W2 = 16'h4567,
  parameter logic [15:0] W3 = 16'h0123
) (
  input  wire logic i_cs,
  input  wire logic i_sk,
  input  wire logic i_dev_data,
  input  wire logic i_dev_oe_n,
  output logic      o_pin
);
  logic [4:0]  nbit  = 5'h00;
  logic [8:0]  cmd   = 9'h000;
  logic [15:0] sh    = 16'h0000;
  logic        drive = 1'b0;
  logic        mout  = 1'b0;
  logic        rel   = 1'b0;

  // Bits are counted on rising clock edges within one select; a read answers MSB first.
  always @(posedge i_sk or negedge i_cs) begin
    if (!i_cs) begin
      rel = ~mout;
      nbit = 5'h00;
      drive = 1'b0;
    end else begin
      nbit = nbit + 5'h01;
      if (nbit <= 5'h09) cmd = {cmd[7:0], i_dev_data};
      if (nbit == 5'h09) begin
        sh = (cmd[5:0] == 6'h01) ? W1 : (cmd[5:0] == 6'h02) ? W2 :
             (cmd[5:0] == 6'h03) ? W3 : 16'h0000;
      end
      drive = (nbit >= 5'h0A) && (nbit <= 5'h19) && (cmd[8:6] == 3'h6);
      if (drive) begin
        mout = sh[15];
        sh = {sh[14:0], 1'b0};
      end
    end
  end

  // A released line shows the inverse of its last value, never a held copy.
  assign o_pin = !i_dev_oe_n ? i_dev_data : (drive ? mout : rel);
endmodule

// File: hcr_top.sv
// Host configuration registers: straps, host station address, serial PROM pins, self-test status.
// Assumes a register port on the system clock and asynchronous strap and PROM data pins.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "hcr_map.svh"

// Notes on behaviour
// - Endian strap latched into bit 10.
// - PROM presence strap latched into bit 9.
// - Bit 7 set for 8-bit bus.
// - Bit 6 set for 16-bit bus.
// - Bit 4 always reads one, shared bus.
// - Present PROM loads address from word 1.
// - Words 1, 2, 3 fill low, mid, high.
// - Address writes never touch the PROM.
// - Access bit 4 hands pins to bits 3-0.
// - Write-only bit 5 picks read or write.
// - Bit 3 reads the live data pin.
// - Bit 2 drives the data out pin.
// - Bit 1 drives the serial clock pin.
// - Bit 0 drives chip select, resets low.
// - Both memories self-test after reset, results read-only.
// - Bit 15 reads done, resets zero.
// - Bit 12 shows transmit test completed.
// - Bit 11 shows transmit test failed.
// - Bits 10-8 give transmit fail count.
// - Global reset bit 3 starts, stops self-test.
// - Bits 4-0 give receive results.
module hcr_top (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [8:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_endian_strap_pin,
  input  wire logic        i_bus_width_strap_pin,
  input  wire logic        i_prom_presence_strap_pin,
  input  wire logic        i_prom_data_pin,
  output logic             o_prom_data_pin,
  output logic             o_prom_data_pin_oe_n,
  output logic             o_prom_clock_pin,
  output logic             o_prom_select_pin
);
  import hcr_pkg::*;

  localparam logic [6:0] HALF = 7'(`HCR_PROM_HALF_CYC - 1);

  hcr_top_state_t r;
  hcr_top_state_t n;
  logic           tick;
  logic           loading;
  logic           tx_done;
  logic           tx_fail;
  logic [2:0]     tx_cnt;
  logic           rx_done;
  logic           rx_fail;
  logic [2:0]     rx_cnt;

  function automatic logic [15:0] cmd(input logic [1:0] w);
    cmd = {`HCR_PROM_READ_OP, 4'h0, w, 7'h00};
  endfunction

  hcr_bist u_tx_bist (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_run  (r.bist_run),
    .o_done (tx_done),
    .o_fail (tx_fail),
    .o_cnt  (tx_cnt)
  );

  hcr_bist u_rx_bist (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_run  (r.bist_run),
    .o_done (rx_done),
    .o_fail (rx_fail),
    .o_cnt  (rx_cnt)
  );

  assign tick = (r.div == 7'h00);
  assign loading = (r.st != HCR_IDLE);

  always_comb begin
    n = r;
    n.s1 = {i_endian_strap_pin, i_bus_width_strap_pin, i_prom_presence_strap_pin,
            i_prom_data_pin};
    n.s2 = r.s1;
    n.div = tick ? HALF : r.div - 7'h01;
    n.rdata = 16'h0000;
    case (r.st)
      HCR_SYNC: begin
        if (r.wait_cnt == 2'h0) begin
          n.endian  = r.s2[3];
          n.wide16  = r.s2[2];
          n.present = r.s2[1];
          n.word    = `HCR_MAC_FIRST;
          n.sh      = cmd(`HCR_MAC_FIRST);
          n.bits    = `HCR_PROM_BITS;
          n.ld_cs   = r.s2[1];
          n.st      = r.s2[1] ? HCR_LOAD : HCR_IDLE;
        end else begin
          n.wait_cnt = r.wait_cnt - 2'h1;
        end
      end
      HCR_LOAD: begin
        if (tick) begin
          n.ph = !r.ph;
          n.ld_sk = !r.ph;
          if (r.ph) begin
            n.sh = {r.sh[14:0], r.s2[0]};
            n.bits = r.bits - 5'h01;
            if (r.bits == 5'h01) begin
              n.mac[2'(r.word - 2'h1)] = {r.sh[14:0], r.s2[0]};
              n.ld_cs = 1'b0;
              n.st = HCR_GAP;
            end
          end
        end
      end
      HCR_GAP: begin
        if (tick) begin
          if (r.word == `HCR_MAC_LAST) begin
            n.st = HCR_IDLE;
          end else begin
            n.word = r.word + 2'h1;
            n.sh = cmd(r.word + 2'h1);
            n.bits = `HCR_PROM_BITS;
            n.ld_cs = 1'b1;
            n.st = HCR_LOAD;
          end
        end
      end
      default: begin
        n.st = HCR_IDLE;
      end
    endcase
    if (loading) begin
      n.cs_o = r.ld_cs;
      n.sk_o = r.ld_sk;
      n.do_o = r.sh[15];
      n.oe_n = !(r.ld_cs && r.bits > `HCR_PROM_DATA_BITS);
    end else begin
      n.cs_o = r.ee_en & r.ee_cs;
      n.sk_o = r.ee_en & r.ee_sk;
      n.do_o = r.ee_en & r.ee_dout;
      n.oe_n = !(r.ee_en & r.ee_dir);
    end
    if (r.grr_bist) begin
      n.bist_run = 1'b1;
    end
    if (i_wr) begin
      case (i_addr)
        `HCR_OFF_MAC_LO:  if (!loading) n.mac[0] = i_wdata;
        `HCR_OFF_MAC_MID: if (!loading) n.mac[1] = i_wdata;
        `HCR_OFF_MAC_HI:  if (!loading) n.mac[2] = i_wdata;
        `HCR_OFF_PROM_CTL: begin
          if (!loading) begin
            n.ee_dir  = i_wdata[`HCR_CTL_DIR];
            n.ee_en   = i_wdata[`HCR_CTL_EN];
            n.ee_dout = i_wdata[`HCR_CTL_DOUT];
            n.ee_sk   = i_wdata[`HCR_CTL_SK];
            n.ee_cs   = i_wdata[`HCR_CTL_CS];
          end
        end
        `HCR_OFF_GLB_RST: begin
          n.grr_bist = i_wdata[`HCR_GRR_BIST];
          // A low cycle lets a second start request restart a finished run.
          n.bist_run = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `HCR_OFF_CFG: begin
          n.rdata[3:0] = `HCR_CFG_LOW_RST;
          n.rdata[`HCR_CFG_ENDIAN]  = r.endian;
          n.rdata[`HCR_CFG_PRESENT] = r.present;
          n.rdata[`HCR_CFG_W8]      = !r.wide16;
          n.rdata[`HCR_CFG_W16]     = r.wide16;
          n.rdata[`HCR_CFG_SHARED]  = 1'b1;
        end
        `HCR_OFF_MAC_LO:  n.rdata = loading ? 16'h0000 : r.mac[0];
        `HCR_OFF_MAC_MID: n.rdata = loading ? 16'h0000 : r.mac[1];
        `HCR_OFF_MAC_HI:  n.rdata = loading ? 16'h0000 : r.mac[2];
        `HCR_OFF_PROM_CTL: begin
          n.rdata[`HCR_CTL_EN]   = r.ee_en;
          n.rdata[`HCR_CTL_DIN]  = r.s2[0];
          n.rdata[`HCR_CTL_DOUT] = r.ee_dout;
          n.rdata[`HCR_CTL_SK]   = r.ee_sk;
          n.rdata[`HCR_CTL_CS]   = r.ee_cs;
        end
        `HCR_OFF_BIST_STAT: begin
          n.rdata = {tx_done & rx_done, 2'b00, tx_done, tx_fail, tx_cnt,
                     3'b000, rx_done, rx_fail, rx_cnt};
        end
        `HCR_OFF_GLB_RST: n.rdata[`HCR_GRR_BIST] = r.grr_bist;
        default: n.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
      r.st <= HCR_SYNC;
      r.wait_cnt <= `HCR_SYNC_WAIT;
      r.oe_n <= 1'b1;
      r.bist_run <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_rdata              = r.rdata;
  assign o_prom_data_pin      = r.do_o;
  assign o_prom_data_pin_oe_n = r.oe_n;
  assign o_prom_clock_pin     = r.sk_o;
  assign o_prom_select_pin    = r.cs_o;

  a_cfg_endian: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == `HCR_OFF_CFG) |=> o_rdata[`HCR_CFG_ENDIAN] == $past(r.endian))
    else $error("Endian bit does not match latched strap.");
  a_cfg_present: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (r.st == HCR_SYNC && r.wait_cnt == 2'h0) |=> r.present == $past(r.s2[1]))
    else $error("Presence strap not latched.");
  a_cfg_width: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == `HCR_OFF_CFG) |=> (o_rdata[7:6] == {!r.wide16, r.wide16}) && o_rdata[4])
    else $error("Bus width or shared bits wrong.");
  a_pin_disabled: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!loading && !r.ee_en) |=> !o_prom_select_pin && !o_prom_clock_pin && o_prom_data_pin_oe_n)
    else $error("PROM pins active while access disabled.");
  a_pin_follow: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!loading && r.ee_en) |=> o_prom_clock_pin == $past(r.ee_sk) && o_prom_select_pin == $past(r.ee_cs))
    else $error("PROM clock or select not following control bits.");
  a_pin_dir: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!loading && r.ee_en && r.ee_dir) |=> !o_prom_data_pin_oe_n && o_prom_data_pin == $past(r.ee_dout))
    else $error("PROM data pin not driven in write direction.");
  a_din_live: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == `HCR_OFF_PROM_CTL) |=> o_rdata[`HCR_CTL_DIN] == $past(r.s2[0]))
    else $error("Data pin status bit wrong.");
  a_load_word: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (r.st == HCR_LOAD && tick && r.ph && r.bits == 5'h01)
    |=> r.mac[$past(r.word) - 2'h1] == $past({r.sh[14:0], r.s2[0]}) ##1 r.st == HCR_GAP)
    else $error("Loaded word went to the wrong address register.");
  a_load_block: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (loading && i_rd && i_addr == `HCR_OFF_MAC_LO) |=> o_rdata == 16'h0000)
    else $error("Address read honoured during automatic load.");
  a_bist_done: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == `HCR_OFF_BIST_STAT) |=> o_rdata[15] == $past(tx_done & rx_done))
    else $error("Self-test done bit wrong.");
  a_stat_tx_fields: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == `HCR_OFF_BIST_STAT) |=> o_rdata[12:8] == $past({tx_done, tx_fail, tx_cnt}))
    else $error("Transmit self-test fields wrong.");
  a_bist_restart: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == `HCR_OFF_GLB_RST && i_wdata[`HCR_GRR_BIST]) |-> ##3 !tx_done && !rx_done)
    else $error("Self-test start did not restart the run.");
  a_bist_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == `HCR_OFF_GLB_RST && !i_wdata[`HCR_GRR_BIST]) |=> !r.bist_run)
    else $error("Self-test stop not honoured.");
  a_pin_data: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!loading && r.ee_en) |=> o_prom_data_pin == $past(r.ee_dout))
    else $error("PROM data out not following control bit.");
  a_load_start: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (r.st == HCR_SYNC && r.wait_cnt == 2'h0 && r.s2[1])
    |=> r.st == HCR_LOAD && r.word == `HCR_MAC_FIRST)
    else $error("Automatic load did not start at the first word.");
  a_mac_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!loading && i_wr && i_addr == `HCR_OFF_MAC_MID) |=> r.mac[1] == $past(i_wdata))
    else $error("Address register write not stored.");

  c_load_end: cover property (@(posedge i_clk) disable iff (!i_rstn)
    r.st == HCR_GAP && r.word == `HCR_MAC_LAST && tick);
  c_bist_done: cover property (@(posedge i_clk) disable iff (!i_rstn) tx_done && rx_done);
  c_bist_restart: cover property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == `HCR_OFF_GLB_RST && i_wdata[`HCR_GRR_BIST] && tx_done);
  c_sw_write: cover property (@(posedge i_clk) disable iff (!i_rstn)
    !loading && r.ee_en && r.ee_dir && r.ee_cs);

endmodule

// File: test_host_config_eeprom_bist_regs.sv
// Self-checking bench for the host configuration registers with a PROM model on the pins.
// Assumes hcr_map.svh and hcr_pkg are compiled first.
`timescale 1ns/100ps
`include "hcr_map.svh"

module test_host_config_eeprom_bist_regs;
  import hcr_pkg::*;
  logic        clk, rstn, wr, rd, endian, width, present, pin_lvl;
  logic        dout, oe_n, sk, cs;
  logic [8:0]  addr;
  logic [15:0] wdata, rdata;
  int          fail_count, compares, cycles;

  hcr_top uut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_endian_strap_pin(endian), .i_bus_width_strap_pin(width),
    .i_prom_presence_strap_pin(present), .i_prom_data_pin(pin_lvl), .o_prom_data_pin(dout),
    .o_prom_data_pin_oe_n(oe_n), .o_prom_clock_pin(sk), .o_prom_select_pin(cs));

  hcr_prom_model prom (.i_cs(cs), .i_sk(sk), .i_dev_data(dout), .i_dev_oe_n(oe_n),
    .o_pin(pin_lvl));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A hang counts as a mismatch and goes to the verdict.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic expect_rd(input string name, input logic [8:0] a, input logic [15:0] exp,
                           input logic [15:0] mask);
    logic [15:0] d;
    bus_rd(a, d);
    chk(name, exp & mask, d & mask);
    @(posedge clk);
    #1 chk("rdata_idle", 16'h0000, rdata);
  endtask

  task automatic do_reset(input logic e, input logic w, input logic p);
    @(posedge clk);
    rstn <= 1'b0;
    endian <= e;
    width <= w;
    present <= p;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
  endtask

  // Waits for the automatic load, then checks the three address words.
  task automatic load_check;
    logic [15:0] d;
    int          n;
    d = 16'h0000;
    for (n = 0; n < 6000 && d !== 16'h0123; n++) bus_rd(`HCR_OFF_MAC_HI, d);
    expect_rd("mac_low", `HCR_OFF_MAC_LO, 16'h89AB, 16'hFFFF);
    expect_rd("mac_mid", `HCR_OFF_MAC_MID, 16'h4567, 16'hFFFF);
    expect_rd("mac_high", `HCR_OFF_MAC_HI, 16'h0123, 16'hFFFF);
  endtask

  task automatic strap_and_load;
    do_reset(1'b1, 1'b1, 1'b1);
    expect_rd("mac_low_loading", `HCR_OFF_MAC_LO, 16'h0000, 16'hFFFF);
    bus_wr(`HCR_OFF_MAC_LO, 16'hFFFF);
    bus_wr(`HCR_OFF_PROM_CTL, 16'h0011);
    load_check;
    expect_rd("ctl_after_load", `HCR_OFF_PROM_CTL, 16'h0000, 16'hFFF7);
    expect_rd("cfg_present", `HCR_OFF_CFG, 16'h0652, 16'hFFFF);
  endtask

  task automatic mac_no_write_back;
    bus_wr(`HCR_OFF_MAC_LO, 16'h1111);
    bus_wr(`HCR_OFF_MAC_MID, 16'h2222);
    bus_wr(`HCR_OFF_MAC_HI, 16'h3333);
    expect_rd("mac_mid_sw", `HCR_OFF_MAC_MID, 16'h2222, 16'hFFFF);
    do_reset(1'b1, 1'b1, 1'b1);
    load_check;
  endtask

  task automatic no_prom_config;
    do_reset(1'b0, 1'b0, 1'b0);
    expect_rd("st_running", `HCR_OFF_BIST_STAT, 16'h0000, 16'h8000);
    expect_rd("cfg_none", `HCR_OFF_CFG, 16'h0092, 16'hFFFF);
    expect_rd("ctl_reset", `HCR_OFF_PROM_CTL, 16'h0000, 16'hFFF7);
    chk("select_reset", 16'h0000, {15'h0000, cs});
    bus_wr(`HCR_OFF_MAC_LO, 16'hA1B2);
    bus_wr(`HCR_OFF_MAC_HI, 16'hC3D4);
    expect_rd("mac_low_sw", `HCR_OFF_MAC_LO, 16'hA1B2, 16'hFFFF);
    expect_rd("mac_high_sw", `HCR_OFF_MAC_HI, 16'hC3D4, 16'hFFFF);
  endtask

  task automatic prom_pins;
    logic [15:0] tw [5] = '{16'h0037, 16'h0023, 16'h0035, 16'h0030, 16'h0012};
    logic [3:0]  tp [5] = '{4'hE, 4'h1, 4'hA, 4'h0, 4'h5};
    logic [15:0] exp;
    for (int i = 0; i < 5; i++) begin
      bus_wr(`HCR_OFF_PROM_CTL, tw[i]);
      repeat (2) @(posedge clk);
      #1 chk("pins_cs_sk_do_oen", {12'h000, tp[i]}, {12'h000, cs, sk, dout, oe_n});
      repeat (3) @(posedge clk);
      exp = (tw[i] & 16'h0017) | ((tp[i][1] && !tp[i][0]) ? 16'h0008 : 16'h0000);
      expect_rd("ctl_readback", `HCR_OFF_PROM_CTL, exp, tp[i][0] ? 16'hFFF7 : 16'hFFFF);
    end
  endtask

  task automatic selftest;
    repeat (300) @(posedge clk);
    expect_rd("st_done", `HCR_OFF_BIST_STAT, 16'h9010, 16'hFFFF);
    bus_wr(`HCR_OFF_GLB_RST, 16'h0008);
    expect_rd("grr_start", `HCR_OFF_GLB_RST, 16'h0008, 16'h0008);
    expect_rd("st_restart", `HCR_OFF_BIST_STAT, 16'h0000, 16'h9010);
    repeat (300) @(posedge clk);
    expect_rd("st_redone", `HCR_OFF_BIST_STAT, 16'h9010, 16'hFFFF);
    bus_wr(`HCR_OFF_GLB_RST, 16'h0000);
    bus_wr(`HCR_OFF_BIST_STAT, 16'h0000);
    expect_rd("st_read_only", `HCR_OFF_BIST_STAT, 16'h9010, 16'hFFFF);
  endtask

  task automatic unmapped;
    expect_rd("gap_read", 9'h116, 16'h0000, 16'hFFFF);
    bus_wr(9'h10A, 16'hFFFF);
    expect_rd("gap_write", 9'h10A, 16'h0000, 16'hFFFF);
    bus_wr(`HCR_OFF_CFG, 16'h0000);
    expect_rd("cfg_read_only", `HCR_OFF_CFG, 16'h0092, 16'hFFFF);
  endtask

  initial begin
    {rstn, wr, rd, endian, width, present} = 6'h00;
    addr = 9'h000;
    wdata = 16'h0000;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    strap_and_load;
    mac_no_write_back;
    no_prom_config;
    prom_pins;
    selftest;
    unmapped;
    tally_and_finish;
  end
endmodule
